// File: include/fcoac_pkg.sv
// Operation
// [RULE_01] software matches range code to crystal
// [RULE_02] range code decodes seven bands, 7 reserved
// [RULE_03] port 2 deglitch enables at bits 25/24
// [RULE_04] port 0 deglitch enables at bits 21/20
// [RULE_05] one-shot bit starts timed calibration run
// [RULE_06] hardware clears one-shot bit when done
// [RULE_07] load bit copies initial trim value
// [RULE_08] hardware clears load bit after load
// [RULE_09] continuous calibration runs while bit 1 set
// [RULE_10] select bit chooses factory or calibrated trim
// [RULE_11] twelve-bit read-write adaptation gain
// [RULE_12] step direction bit read-only
// [RULE_13] software preserves reserved control bits 7:5
// [RULE_14] all fields reset to zero; the trim field at 4h4 reads factory_trim_in once reset is released
// [RULE_15] target is multiple times 32768, zero as one
// [RULE_16] run lasts duration field milliseconds
// [RULE_17] nine-bit initial trim at register bottom
// [RULE_18] trim field shows applied oscillator trim
// package: offsets, field layout, reset values, timing counts
// assumes a 32-bit word-aligned slave with byte addresses
package fcoac_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] OFS_FUNC_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CAL_CTRL   = 4'h4;
  localparam logic [3:0] OFS_CAL_INIT   = 4'h8;
  localparam logic [3:0] OFS_CAL_TARGET = 4'hc;
  localparam int P2_CLK_BIT   = 25;
  localparam int P2_DATA_BIT  = 24;
  localparam int P0_CLK_BIT   = 21;
  localparam int P0_DATA_BIT  = 20;
  localparam int RANGE_LSB    = 0;
  localparam int RANGE_W      = 3;
  localparam int TRIM_LSB     = 23;
  localparam int TRIM_W       = 9;
  localparam int GAIN_LSB     = 8;
  localparam int GAIN_W       = 12;
  localparam int ONESHOT_BIT  = 4;
  localparam int INVERT_BIT   = 3;
  localparam int LOAD_BIT     = 2;
  localparam int CONT_BIT     = 1;
  localparam int SEL_BIT      = 0;
  localparam int INIT_LSB     = 0;
  localparam int TARGET_LSB   = 8;
  localparam int TARGET_W     = 13;
  localparam int RUNTIME_LSB  = 0;
  localparam int RUNTIME_W    = 8;
  localparam int BANDS        = 7;
  localparam int CNT_W        = 14;
  localparam int GAIN_SHIFT   = 8;
  localparam logic [2:0] RANGE_RESERVED = 3'h7;
  localparam logic [31:0] RST_ZERO = 32'h0;
  localparam int REF_HZ        = 32768;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [GAIN_W-1:0]   gain;
    logic [TARGET_W-1:0] target;
  } fcoac_cal_cfg_t;

  typedef struct packed {
    logic [TRIM_W-1:0] trim;
    logic              down;
    logic              change;
  } fcoac_step_t;

  function automatic logic [31:0] fcoac_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// File: rtl/fcoac_ms_tick.sv
// file: millisecond enable divider
// assumes restart_in is pulsed when a timed run begins
module fcoac_ms_tick #(
  parameter int CYCLES = fcoac_pkg::MS_CYCLES
) (
  input  wire logic clk_in,     // system clock
  input  wire logic resetn_in,  // async reset, low
  input  wire logic run_in,     // count while high
  input  wire logic restart_in, // restart the period
  output logic      tick_out    // one-cycle ms pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg  <= '0;
      tick_out <= 1'b0;
    end else if (restart_in || !run_in) begin
      cnt_reg  <= '0;
      tick_out <= 1'b0;
    end else if (cnt_reg == CW'(CYCLES - 1)) begin
      cnt_reg  <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule

// File: rtl/fcoac_top.sv
// file: function control bank with oscillator trim calibration
// assumes an Avalon-MM master; tick inputs are one-cycle pulses
//
// Our own choice: the Avalon-MM interface to the registers.
module fcoac_top #(
  parameter int MS_CYCLES = fcoac_pkg::MS_CYCLES
) (
  input  wire logic        clk_in,                        // system clock
  input  wire logic        resetn_in,                     // async reset, low
  input  wire logic [3:0]  avs_address_in,                // byte address
  input  wire logic        avs_read_in,                   // read request
  input  wire logic        avs_write_in,                  // write request
  input  wire logic [31:0] avs_writedata_in,              // write data
  input  wire logic [3:0]  avs_byteenable_in,             // write lanes
  output logic [31:0]      avs_readdata_out,              // read data
  output logic             avs_waitrequest_out,           // stall
  input  wire logic        ipo_tick_in,                   // oscillator edge pulse
  input  wire logic        ref_tick_in,                   // 32768 Hz reference pulse
  input  wire logic [8:0]  factory_trim_in,               // default trim
  output logic             port2_clock_line_deglitch_out, // port 2 clock filter
  output logic             port2_data_line_deglitch_out,  // port 2 data filter
  output logic             port0_clock_line_deglitch_out, // port 0 clock filter
  output logic             port0_data_line_deglitch_out,  // port 0 data filter
  output logic [2:0]       crystal_range_out,             // range code
  output logic [6:0]       crystal_band_out,              // one-hot band
  output logic             crystal_range_reserved_out,    // code 7 written
  output logic [8:0]       internal_primary_oscillator_trim_out, // applied trim
  output logic             cal_busy_out                   // calibration active
);
  typedef enum logic [1:0] {
    FCOAC_IDLE  = 2'b00,
    FCOAC_WAIT  = 2'b01,
    FCOAC_ACK   = 2'b10
  } fcoac_bus_t;

  typedef enum logic [1:0] {
    FCOAC_OFF   = 2'b00,
    FCOAC_ALIGN = 2'b01,
    FCOAC_MEAS  = 2'b10
  } fcoac_cal_t;

  fcoac_bus_t                   bus_reg;
  fcoac_bus_t                   bus_next;
  fcoac_cal_t                   cal_reg;
  fcoac_cal_t                   cal_next;
  logic [31:0]                  fctrl_reg;
  logic [fcoac_pkg::GAIN_W-1:0] gain_reg;
  logic                         oneshot_reg;
  logic                         invert_reg;
  logic                         load_reg;
  logic                         cont_reg;
  logic                         sel_reg;
  logic [fcoac_pkg::TRIM_W-1:0] init_reg;
  logic [fcoac_pkg::TARGET_W-1:0] target_reg;
  logic [fcoac_pkg::RUNTIME_W-1:0] runtime_reg;
  logic [fcoac_pkg::RUNTIME_W-1:0] ms_left_reg;
  logic [fcoac_pkg::TRIM_W-1:0] cal_trim_reg;
  logic [fcoac_pkg::CNT_W-1:0]  count_reg;
  logic [31:0]                  ctrl_word;
  logic [31:0]                  ctrl_merged;
  logic [31:0]                  rd_word;
  logic                         accept;
  logic                         wr_fire;
  logic                         wr_ctrl;
  logic                         start_run;
  logic                         run_done;
  logic                         calibrating;
  logic                         step_now;
  logic                         ms_tick;
  fcoac_pkg::fcoac_cal_cfg_t    cal_cfg;
  fcoac_pkg::fcoac_step_t       step;

  // bus handshake: one wait cycle, answer at the second edge
  assign accept  = (avs_read_in || avs_write_in) && (bus_reg == FCOAC_ACK);
  assign wr_fire = accept && avs_write_in;
  assign wr_ctrl = wr_fire && (avs_address_in == fcoac_pkg::OFS_CAL_CTRL);

  always_comb begin
    bus_next = bus_reg;
    case (bus_reg)
      FCOAC_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          bus_next = FCOAC_ACK;
        end
      end
      FCOAC_ACK: begin
        bus_next = FCOAC_WAIT;
      end
      FCOAC_WAIT: begin
        bus_next = FCOAC_IDLE;
      end
      default: begin
        bus_next = FCOAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_reg             <= FCOAC_IDLE;
      avs_waitrequest_out <= 1'b1;
    end else begin
      bus_reg             <= bus_next;
      avs_waitrequest_out <= (bus_next != FCOAC_ACK);
    end
  end

  // control word as software sees it
  always_comb begin
    ctrl_word = fcoac_pkg::RST_ZERO;
    ctrl_word[fcoac_pkg::TRIM_LSB +: fcoac_pkg::TRIM_W] = internal_primary_oscillator_trim_out; // RULE_18
    ctrl_word[fcoac_pkg::GAIN_LSB +: fcoac_pkg::GAIN_W] = gain_reg; // RULE_11
    ctrl_word[fcoac_pkg::ONESHOT_BIT] = oneshot_reg;
    ctrl_word[fcoac_pkg::INVERT_BIT]  = invert_reg; // RULE_12
    ctrl_word[fcoac_pkg::LOAD_BIT]    = load_reg;
    ctrl_word[fcoac_pkg::CONT_BIT]    = cont_reg;
    ctrl_word[fcoac_pkg::SEL_BIT]     = sel_reg;
  end

  assign ctrl_merged = fcoac_pkg::fcoac_merge(rd_word, avs_writedata_in, avs_byteenable_in);

  always_comb begin
    rd_word = fcoac_pkg::RST_ZERO;
    case (avs_address_in)
      fcoac_pkg::OFS_FUNC_CTRL0: begin
        rd_word = fctrl_reg;
      end
      fcoac_pkg::OFS_CAL_CTRL: begin
        rd_word = ctrl_word;
      end
      fcoac_pkg::OFS_CAL_INIT: begin
        rd_word[fcoac_pkg::INIT_LSB +: fcoac_pkg::TRIM_W] = init_reg; // RULE_17
      end
      fcoac_pkg::OFS_CAL_TARGET: begin
        rd_word[fcoac_pkg::TARGET_LSB +: fcoac_pkg::TARGET_W]   = target_reg;
        rd_word[fcoac_pkg::RUNTIME_LSB +: fcoac_pkg::RUNTIME_W] = runtime_reg;
      end
      default: begin
        rd_word = fcoac_pkg::RST_ZERO;
      end
    endcase
  end

  // read data sampled one edge ahead of the accepting edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= fcoac_pkg::RST_ZERO;
    end else if (bus_next == FCOAC_ACK) begin
      avs_readdata_out <= rd_word;
    end
  end

  // function control: only the deglitch and range fields are storable
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fctrl_reg <= fcoac_pkg::RST_ZERO; // RULE_14
    end else if (wr_fire && avs_address_in == fcoac_pkg::OFS_FUNC_CTRL0) begin
      fctrl_reg <= fcoac_pkg::RST_ZERO;
      fctrl_reg[fcoac_pkg::P2_CLK_BIT]  <= avs_byteenable_in[3] ? avs_writedata_in[fcoac_pkg::P2_CLK_BIT]
                                                                : fctrl_reg[fcoac_pkg::P2_CLK_BIT];
      fctrl_reg[fcoac_pkg::P2_DATA_BIT] <= avs_byteenable_in[3] ? avs_writedata_in[fcoac_pkg::P2_DATA_BIT]
                                                                : fctrl_reg[fcoac_pkg::P2_DATA_BIT];
      fctrl_reg[fcoac_pkg::P0_CLK_BIT]  <= avs_byteenable_in[2] ? avs_writedata_in[fcoac_pkg::P0_CLK_BIT]
                                                                : fctrl_reg[fcoac_pkg::P0_CLK_BIT];
      fctrl_reg[fcoac_pkg::P0_DATA_BIT] <= avs_byteenable_in[2] ? avs_writedata_in[fcoac_pkg::P0_DATA_BIT]
                                                                : fctrl_reg[fcoac_pkg::P0_DATA_BIT];
      fctrl_reg[fcoac_pkg::RANGE_LSB +: fcoac_pkg::RANGE_W] <= avs_byteenable_in[0] ?
        avs_writedata_in[fcoac_pkg::RANGE_LSB +: fcoac_pkg::RANGE_W] :
        fctrl_reg[fcoac_pkg::RANGE_LSB +: fcoac_pkg::RANGE_W];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port2_clock_line_deglitch_out <= 1'b0;
      port2_data_line_deglitch_out  <= 1'b0;
      port0_clock_line_deglitch_out <= 1'b0;
      port0_data_line_deglitch_out  <= 1'b0;
      crystal_range_out             <= 3'h0;
      crystal_band_out              <= 7'h00;
      crystal_range_reserved_out    <= 1'b0;
    end else begin
      port2_clock_line_deglitch_out <= fctrl_reg[fcoac_pkg::P2_CLK_BIT];  // RULE_03
      port2_data_line_deglitch_out  <= fctrl_reg[fcoac_pkg::P2_DATA_BIT]; // RULE_03
      port0_clock_line_deglitch_out <= fctrl_reg[fcoac_pkg::P0_CLK_BIT];  // RULE_04
      port0_data_line_deglitch_out  <= fctrl_reg[fcoac_pkg::P0_DATA_BIT]; // RULE_04
      crystal_range_out <= fctrl_reg[fcoac_pkg::RANGE_LSB +: fcoac_pkg::RANGE_W];
      crystal_range_reserved_out <= fctrl_reg[fcoac_pkg::RANGE_LSB +: fcoac_pkg::RANGE_W]
                                    == fcoac_pkg::RANGE_RESERVED; // RULE_02
      if (fctrl_reg[fcoac_pkg::RANGE_LSB +: fcoac_pkg::RANGE_W] == fcoac_pkg::RANGE_RESERVED) begin
        crystal_band_out <= 7'h00; // RULE_02
      end else begin
        crystal_band_out <= 7'h01 << fctrl_reg[fcoac_pkg::RANGE_LSB +: fcoac_pkg::RANGE_W]; // RULE_02
      end
    end
  end

  // calibration control fields; bits 7:5 are not stored and read zero
  assign start_run = wr_ctrl && avs_byteenable_in[0] && avs_writedata_in[fcoac_pkg::ONESHOT_BIT];
  assign run_done  = oneshot_reg && !start_run && (ms_left_reg == '0);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gain_reg <= '0;
      cont_reg <= 1'b0;
      sel_reg  <= 1'b0;
    end else if (wr_ctrl) begin
      gain_reg <= ctrl_merged[fcoac_pkg::GAIN_LSB +: fcoac_pkg::GAIN_W]; // RULE_11
      cont_reg <= ctrl_merged[fcoac_pkg::CONT_BIT]; // RULE_09
      sel_reg  <= ctrl_merged[fcoac_pkg::SEL_BIT];  // RULE_10
    end
  end

  // one-shot bit: software sets, hardware clears at end of run
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      oneshot_reg <= 1'b0;
    end else if (start_run) begin
      oneshot_reg <= 1'b1; // RULE_05
    end else if (run_done) begin
      oneshot_reg <= 1'b0; // RULE_06
    end
  end

  // remaining milliseconds of the timed run
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ms_left_reg <= '0;
    end else if (start_run) begin
      ms_left_reg <= runtime_reg; // RULE_16
    end else if (oneshot_reg && ms_tick && ms_left_reg != '0) begin
      ms_left_reg <= ms_left_reg - 1'b1; // RULE_16
    end
  end

  fcoac_ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_ms_tick (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .run_in    (oneshot_reg),
    .restart_in(start_run),
    .tick_out  (ms_tick)
  );

  // load bit: a write of one loads next edge, then self-clears
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      load_reg <= 1'b0;
    end else if (wr_ctrl && avs_byteenable_in[0] && avs_writedata_in[fcoac_pkg::LOAD_BIT]) begin
      load_reg <= 1'b1; // RULE_07
    end else begin
      load_reg <= 1'b0; // RULE_08
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      init_reg    <= '0;
      target_reg  <= '0;
      runtime_reg <= '0;
    end else if (wr_fire && avs_address_in == fcoac_pkg::OFS_CAL_INIT) begin
      init_reg <= ctrl_merged[fcoac_pkg::INIT_LSB +: fcoac_pkg::TRIM_W]; // RULE_17
    end else if (wr_fire && avs_address_in == fcoac_pkg::OFS_CAL_TARGET) begin
      target_reg  <= ctrl_merged[fcoac_pkg::TARGET_LSB +: fcoac_pkg::TARGET_W];
      runtime_reg <= ctrl_merged[fcoac_pkg::RUNTIME_LSB +: fcoac_pkg::RUNTIME_W]; // RULE_16
    end
  end

  // measurement: count oscillator ticks over whole reference periods
  assign calibrating = cont_reg || oneshot_reg; // RULE_09

  always_comb begin
    cal_next = cal_reg;
    case (cal_reg)
      FCOAC_OFF: begin
        if (calibrating) begin
          cal_next = FCOAC_ALIGN;
        end
      end
      FCOAC_ALIGN: begin
        if (!calibrating) begin
          cal_next = FCOAC_OFF;
        end else if (ref_tick_in) begin
          cal_next = FCOAC_MEAS;
        end
      end
      FCOAC_MEAS: begin
        if (!calibrating) begin
          cal_next = FCOAC_OFF;
        end
      end
      default: begin
        cal_next = FCOAC_OFF;
      end
    endcase
  end

  assign step_now = (cal_reg == FCOAC_MEAS) && calibrating && ref_tick_in;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cal_reg      <= FCOAC_OFF;
      cal_busy_out <= 1'b0;
    end else begin
      cal_reg      <= cal_next;
      cal_busy_out <= cal_next != FCOAC_OFF;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= '0;
    end else if (cal_reg != FCOAC_MEAS || ref_tick_in) begin
      count_reg <= '0;
    end else if (ipo_tick_in && count_reg != '1) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign cal_cfg.gain   = gain_reg;
  assign cal_cfg.target = target_reg;

  fcoac_trim_adapt u_adapt (
    .count_in(count_reg),
    .cfg_in  (cal_cfg),
    .trim_in (cal_trim_reg),
    .step_out(step)
  );

  // calibrated trim: a load takes priority over a step
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cal_trim_reg <= '0;
      invert_reg   <= 1'b0;
    end else if (load_reg) begin
      cal_trim_reg <= init_reg; // RULE_07
    end else if (step_now) begin
      cal_trim_reg <= step.trim; // RULE_18
      if (step.change) begin
        invert_reg <= step.down; // RULE_12
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      internal_primary_oscillator_trim_out <= '0;
    end else if (sel_reg) begin
      internal_primary_oscillator_trim_out <= cal_trim_reg; // RULE_10
    end else begin
      internal_primary_oscillator_trim_out <= factory_trim_in; // RULE_10
    end
  end
endmodule

// File: rtl/fcoac_trim_adapt.sv
// file: one calibration step of the oscillator trim
// assumes count_in holds oscillator ticks over one reference period
module fcoac_trim_adapt (
  input  wire logic [fcoac_pkg::CNT_W-1:0]  count_in, // measured ticks
  input  wire fcoac_pkg::fcoac_cal_cfg_t    cfg_in,   // gain and target
  input  wire logic [fcoac_pkg::TRIM_W-1:0] trim_in,  // present trim
  output fcoac_pkg::fcoac_step_t            step_out  // next trim
);
  localparam int PW = fcoac_pkg::CNT_W + fcoac_pkg::GAIN_W;
  logic [fcoac_pkg::CNT_W-1:0]  target;
  logic [fcoac_pkg::CNT_W-1:0]  diff;
  logic [PW-1:0]                prod;
  logic [PW-1:0]                scaled;
  logic [fcoac_pkg::TRIM_W-1:0] step;
  logic [fcoac_pkg::TRIM_W:0]   sum;
  logic                         down;

  always_comb begin
    target = (cfg_in.target == '0) ? fcoac_pkg::CNT_W'(1) : fcoac_pkg::CNT_W'(cfg_in.target); // RULE_15
    down   = count_in > target;
    diff   = down ? count_in - target : target - count_in;
    prod   = PW'(diff) * PW'(cfg_in.gain); // RULE_11
    scaled = prod >> fcoac_pkg::GAIN_SHIFT;
    if (scaled == '0) begin
      step = fcoac_pkg::TRIM_W'(1);
    end else if (scaled > PW'({fcoac_pkg::TRIM_W{1'b1}})) begin
      step = '1;
    end else begin
      step = scaled[fcoac_pkg::TRIM_W-1:0];
    end
    sum = {1'b0, trim_in} + {1'b0, step};
    step_out.change = diff != '0;
    step_out.down   = down;
    if (diff == '0) begin
      step_out.trim = trim_in;
    end else if (down) begin
      step_out.trim = (trim_in > step) ? trim_in - step : '0;
    end else begin
      step_out.trim = sum[fcoac_pkg::TRIM_W] ? '1 : sum[fcoac_pkg::TRIM_W-1:0];
    end
  end
endmodule

// File: tb/fcoac_top_bench.sv
// self-checking bench for the function control bank
// assumes fcoac_top with a short millisecond count
module fcoac_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hf, tick_cnt = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, rd, avs_readdata_out;
  logic ipo_tick_in = 1'b0, ref_tick_in = 1'b0, avs_waitrequest_out, p2c, p2d, p0c, p0d, rsv, busy;
  logic [8:0] factory_trim_in = 9'h0a5, trim, t0;
  logic [2:0] rng;
  logic [6:0] band;
  int fail_count = 0, cmp_count = 0, cyc = 0, start;
  fcoac_top #(.MS_CYCLES(20)) fcoac_top_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .ipo_tick_in(ipo_tick_in), .ref_tick_in(ref_tick_in), .factory_trim_in(factory_trim_in),
    .port2_clock_line_deglitch_out(p2c), .port2_data_line_deglitch_out(p2d),
    .port0_clock_line_deglitch_out(p0c), .port0_data_line_deglitch_out(p0d),
    .crystal_range_out(rng), .crystal_band_out(band), .crystal_range_reserved_out(rsv),
    .internal_primary_oscillator_trim_out(trim), .cal_busy_out(busy));
  always #2 clk_in = ~clk_in;
  // oscillator pulse every 2 cycles, reference every 16
  always @(posedge clk_in) begin
    tick_cnt <= tick_cnt + 4'h1;
    ipo_tick_in <= tick_cnt[0];
    ref_tick_in <= (tick_cnt == 4'hf);
  end
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
  endtask
  task automatic bus_read(input logic [3:0] a);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
  endtask
  task automatic read_check(input logic [3:0] a, input logic [31:0] exp);
    bus_read(a);
    check(rd, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  initial begin
    wait_cyc(16);
    resetn_in <= 1'b1;
    read_check(4'h0, 32'h0);
    read_check(4'h4, {9'h0a5, 23'h0});
    read_check(4'h8, 32'h0);
    read_check(4'hc, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus_write(4'h0, 32'(i), 4'hf);
      read_check(4'h0, 32'(i));
      check(band, (i == 7) ? 7'h0 : 7'h1 << i);
      check(rsv, i == 7);
    end
    bus_write(4'h0, 32'hffff_ffff, 4'hf);
    read_check(4'h0, 32'h0330_0007);
    check({p2c, p2d, p0c, p0d}, 4'hf);
    bus_write(4'h0, 32'h0, 4'h4);
    read_check(4'h0, 32'h0300_0007);
    check({p2c, p2d, p0c, p0d}, 4'hc);
    bus_write(4'h1, 32'hffff_ffff, 4'hf);
    read_check(4'h2, 32'h0);
    bus_write(4'h4, 32'h000f_ff08, 4'hf);
    read_check(4'h4, {9'h0a5, 23'h0} | 32'h000f_ff00);
    bus_write(4'h8, 32'hffff_ffff, 4'hf);
    read_check(4'h8, 32'h0000_01ff);
    bus_write(4'hc, 32'hffff_ffff, 4'hf);
    read_check(4'hc, 32'h001f_ffff);
    bus_write(4'h4, 32'h0001_0005, 4'hf);
    wait_cyc(4);
    check(trim, 9'h1ff);
    read_check(4'h4, 32'hff81_0001);
    bus_write(4'hc, 32'h0000_0403, 4'hf);
    start = cyc;
    bus_write(4'h4, 32'h0001_0011, 4'hf);
    do bus_read(4'h4); while (rd[4] !== 1'b0);
    check(cyc - start >= 60, 1'b1);
    check(rd[3], 1'b1);
    check(trim < 9'h1ff, 1'b1);
    wait_cyc(3);
    check(busy, 1'b0);
    read_check(4'h4, {trim, 23'h01_0009});
    bus_write(4'h4, 32'h0001_0003, 4'hf);
    wait_cyc(5);
    check(busy, 1'b1);
    t0 = trim;
    wait_cyc(100);
    check(trim < t0, 1'b1);
    bus_write(4'h4, 32'h0001_0001, 4'hf);
    wait_cyc(40);
    t0 = trim;
    wait_cyc(100);
    check(trim, t0);
    check(busy, 1'b0);
    bus_write(4'h4, 32'h0, 4'hf);
    wait_cyc(3);
    check(trim, 9'h0a5);
    bus_write(4'h0, 32'hffff_ffff, 4'hf);
    resetn_in <= 1'b0;
    wait_cyc(16);
    resetn_in <= 1'b1;
    read_check(4'h0, 32'h0);
    check(p2c, 1'b0);
    wrap_up();
  end
endmodule

// File: tb/fcoac_top_monitor.sv
// checker for the function control bank, bus and control outputs
// assumes a single clock domain and bind onto fcoac_top
module fcoac_top_monitor #(
  parameter int MS_CYCLES = 20
) (
  input wire logic        clk_in,                        // clock
  input wire logic        resetn_in,                     // reset, low
  input wire logic [3:0]  avs_address_in,                // address
  input wire logic        avs_read_in,                   // read
  input wire logic        avs_write_in,                  // write
  input wire logic [31:0] avs_writedata_in,              // write data
  input wire logic [3:0]  avs_byteenable_in,             // lanes
  input wire logic [31:0] avs_readdata_out,              // read data
  input wire logic        avs_waitrequest_out,           // stall
  input wire logic        port2_clock_line_deglitch_out, // filter
  input wire logic        port2_data_line_deglitch_out,  // filter
  input wire logic        port0_clock_line_deglitch_out, // filter
  input wire logic        port0_data_line_deglitch_out,  // filter
  input wire logic [2:0]  crystal_range_out,             // range
  input wire logic [6:0]  crystal_band_out,              // band
  input wire logic        crystal_range_reserved_out,    // code 7
  input wire logic        cal_busy_out                   // busy
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic wr0, rd0, rd4;
  assign wr0 = avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0;
  assign rd0 = avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0;
  assign rd4 = avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h4;
  a_port2_filter_follow: assert property (wr0 && avs_byteenable_in[3] |-> ##2
    {port2_clock_line_deglitch_out, port2_data_line_deglitch_out} == $past(avs_writedata_in[25:24], 2))
    else $error("port 2 filter enables do not follow write");
  a_port0_filter_follow: assert property (wr0 && avs_byteenable_in[2] |-> ##2
    {port0_clock_line_deglitch_out, port0_data_line_deglitch_out} == $past(avs_writedata_in[21:20], 2))
    else $error("port 0 filter enables do not follow write");
  a_range_band_decode: assert property (rd0 |-> crystal_range_reserved_out == (crystal_range_out == 3'h7) &&
    crystal_band_out == ((crystal_range_out == 3'h7) ? 7'h00 : 7'h01 << crystal_range_out))
    else $error("band decode wrong");
  a_ctrl_readback: assert property (rd0 |-> avs_readdata_out[2:0] == crystal_range_out &&
    avs_readdata_out[31:26] == 6'h00 && avs_readdata_out[23:22] == 2'h0 && avs_readdata_out[19:3] == 17'h0)
    else $error("control register read mismatch");
  a_calctl_reserved: assert property (rd4 |-> avs_readdata_out[22:20] == 3'h0 && avs_readdata_out[7:5] == 3'h0)
    else $error("reserved calibration bits not zero");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in[1:0] != 2'h0
    |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_answer_bound: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |-> ##[1:3] !avs_waitrequest_out)
    else $error("bus request not answered");
  a_oneshot_busy: assert property (avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h4 &&
    avs_byteenable_in[0] && avs_writedata_in[4] |-> ##[1:3] cal_busy_out) else $error("one-shot run not started");
  c_oneshot: cover property (avs_write_in && !avs_waitrequest_out && avs_writedata_in[4]);
  c_read_cal: cover property (rd4);
  c_reserved: cover property (crystal_range_reserved_out);
endmodule
bind fcoac_top fcoac_top_monitor #(.MS_CYCLES(MS_CYCLES)) fcoac_top_monitor_inst (.clk_in(clk_in),
  .resetn_in(resetn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .port2_clock_line_deglitch_out(port2_clock_line_deglitch_out), .crystal_range_out(crystal_range_out),
  .port2_data_line_deglitch_out(port2_data_line_deglitch_out), .crystal_range_reserved_out(crystal_range_reserved_out),
  .port0_clock_line_deglitch_out(port0_clock_line_deglitch_out), .crystal_band_out(crystal_band_out),
  .port0_data_line_deglitch_out(port0_data_line_deglitch_out), .cal_busy_out(cal_busy_out));
